// >>> verilog/mpi_ctrl.sv
`timescale 1ns/100ps
module mpi_ctrl
	import mpi_pkg::*;
(
	input  wire  logic               core_clk,
	input  wire  logic               srst,
	// Pins from outside the core clock domain
	input  wire  logic               ext0_in,
	input  wire  logic               ext1_out_en_in,
	input  wire  logic               rx_pin_in,
	input  wire  logic               card_detect_in,
	// Flags from other on-chip blocks
	input  wire  logic               timer0_overflow_flag,
	input  wire  logic               timer1_overflow_flag,
	input  wire  logic               rx_done_flag,
	input  wire  logic               tx_done_flag,
	input  wire  logic               card_if_irq,
	// Enable bits
	input  wire  logic               global_irq_enable,
	input  wire  logic               ext0_enable,
	input  wire  logic               timer0_irq_en,
	input  wire  logic               ext1_enable,
	input  wire  logic               timer1_irq_en,
	input  wire  logic               serial_irq_en,
	input  wire  logic               card_if_irq_en,
	// Priority bits, indexed by source
	input  wire  logic [NUM_SRC-1:0] prio_high_bit,
	input  wire  logic [NUM_SRC-1:0] prio_low_bit,
	// Trigger configuration
	input  wire  logic               ext0_edge_select,
	input  wire  logic               ext1_edge_select,
	input  wire  logic               out_en_irq_en,
	input  wire  logic               out_en_level_sel,
	input  wire  logic               rx_pin_irq_en,
	input  wire  logic               card_detect_irq_en,
	input  wire  logic               card_detect_level_sel,
	// Software clears
	input  wire  logic               rx_pin_flag_clr,
	input  wire  logic               card_detect_flag_clr,
	// Processor handshake
	input  wire  logic               irq_ack,
	input  wire  logic               irq_return,
	output logic                     irq_req_r,
	output logic [VEC_W-1:0]         irq_vector_r,
	output logic [LVL_W-1:0]         irq_level_r,
	output logic [LVL_W+1:0]         in_service_r,
	// Flags and clear strobes
	output logic                     ext0_flag_r,
	output logic                     ext1_flag_r,
	output logic                     rx_pin_flag_r,
	output logic                     card_detect_flag_r,
	output logic                     timer0_flag_clr_r,
	output logic                     timer1_flag_clr_r
);

	logic [NUM_PIN-1:0] pin_meta_r;
	logic [NUM_PIN-1:0] pin_sync_r;
	logic [NUM_PIN-1:0] pin_prev_r;
	logic [SRC_W-1:0]   req_src_r;
	logic [NUM_SRC-1:0] src_en;
	logic [NUM_SRC-1:0] src_flag;
	logic [NUM_SRC-1:0] pend;
	logic               grp_ext1;
	logic               best_found;
	logic [LVL_W-1:0]   best_lvl;
	logic [SRC_W-1:0]   best_src;
	logic [LVL_W-1:0]   cur_lvl;
	logic               take;
	logic               ack_ok;
	logic               ext1_pin_active;
	logic               ext1_fall;
	logic               ext0_fall;
	logic               card_hit;

	function automatic logic [VEC_W-1:0] vec_of(input logic [SRC_W-1:0] s);
		logic [VEC_W-1:0] v;
		v = VEC_EXT0;
		unique case (s)
			SRC_EXT0:   v = VEC_EXT0;
			SRC_TMR0:   v = VEC_TMR0;
			SRC_EXT1:   v = VEC_EXT1;
			SRC_TMR1:   v = VEC_TMR1;
			SRC_SERIAL: v = VEC_SERIAL;
			SRC_CARD:   v = VEC_CARD;
			default:    v = VEC_EXT0;
		endcase
		return v;
	endfunction

	// Two-stage synchroniser; only the second stage is looked at.
	// A third stage keeps the previous settled value for edge detection.
	// Reset presets all stages high, the idle level of every pin, so no
	// false falling edge is seen when reset is released.
	// Cost: a pin event reaches its flag three edges after it settles.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pin_meta_r <= PIN_RST;
			pin_sync_r <= PIN_RST;
			pin_prev_r <= PIN_RST;
		end else begin
			pin_meta_r <= {card_detect_in, rx_pin_in, ext1_out_en_in, ext0_in};
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	assign ext0_fall       = pin_prev_r[PIN_EXT0] & ~pin_sync_r[PIN_EXT0];
	assign ext1_fall       = pin_prev_r[PIN_EXT1] & ~pin_sync_r[PIN_EXT1];
	assign ext1_pin_active = (pin_sync_r[PIN_EXT1] == out_en_level_sel);
	// Entering the selected level counts as a presence change
	assign card_hit = (pin_sync_r[PIN_CARD] == card_detect_level_sel) &
			  (pin_prev_r[PIN_CARD] != card_detect_level_sel);

	// An acknowledge with no request standing is ignored, so a stray
	// pulse from the core cannot mark a level as in service
	assign ack_ok = irq_ack & irq_req_r;

	// External 0 flag: falling edge sticky, or follows the low level.
	// In edge mode a new falling edge in the acknowledge cycle keeps the
	// flag set, so that second event is not lost.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ext0_flag_r <= 1'b0;
		end else if (ext0_edge_select) begin
			if (ext0_fall)
				ext0_flag_r <= 1'b1;
			else if (ack_ok && req_src_r == SRC_EXT0)
				ext0_flag_r <= 1'b0;
		end else begin
			ext0_flag_r <= ~pin_sync_r[PIN_EXT0];
		end
	end

	// Output-enable pin flag; the detection set wins over the vector clear.
	// Disabling the pin drops a pending flag at once, so a stale event is
	// not served when the pin is enabled again later.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ext1_flag_r <= 1'b0;
		end else if (!out_en_irq_en) begin
			ext1_flag_r <= 1'b0;
		end else if (ext1_edge_select) begin
			if (ext1_fall)
				ext1_flag_r <= 1'b1;
			else if (ack_ok && req_src_r == SRC_EXT1)
				ext1_flag_r <= 1'b0;
		end else begin
			// Level mode tracks the pin, so a held level requests again
			ext1_flag_r <= ext1_pin_active;
		end
	end

	// Receive pin flag: set while the pin is low, so a software clear
	// only sticks once the line has returned high. The set wins over a
	// clear in the same cycle.
	always_ff @(posedge core_clk) begin
		if (srst)
			rx_pin_flag_r <= 1'b0;
		else if (!pin_sync_r[PIN_RX])
			rx_pin_flag_r <= 1'b1;
		else if (rx_pin_flag_clr)
			rx_pin_flag_r <= 1'b0;
	end

	// Never cleared by the vector: software owns the clear.
	// Only the entry into the selected level counts, so a card that stays
	// present does not set the flag again after software clears it.
	always_ff @(posedge core_clk) begin
		if (srst)
			card_detect_flag_r <= 1'b0;
		else if (card_hit)
			card_detect_flag_r <= 1'b1;
		else if (card_detect_flag_clr)
			card_detect_flag_r <= 1'b0;
	end

	// Group request for the shared vector.
	// Each sub-flag is gated by its own enable; the group as a whole is
	// then gated by the external-1 enable and the global enable below.
	// The vector is not told which sub-source fired: software must look
	// at the individual flags.
	assign grp_ext1 = (ext1_flag_r & out_en_irq_en) |
			  (rx_pin_flag_r & rx_pin_irq_en) |
			  (card_detect_flag_r & card_detect_irq_en);

	assign src_en = {card_if_irq_en, serial_irq_en, timer1_irq_en,
			 ext1_enable, timer0_irq_en, ext0_enable};
	assign src_flag = {card_if_irq, rx_done_flag | tx_done_flag, timer1_overflow_flag,
			   grp_ext1, timer0_overflow_flag, ext0_flag_r};
	assign pend = global_irq_enable ? (src_en & src_flag) : SRC_RST;

	// Walk from the last source down so an equal level at a lower index
	// overwrites: highest level first, then polling order.
	// The arbiter is purely combinational over six sources; the result is
	// registered once, so the request lags its flag by one edge.
	always_comb begin
		logic [LVL_W-1:0] lv;
		lv         = LVL_LOWEST;
		best_found = 1'b0;
		best_lvl   = LVL_LOWEST;
		best_src   = SRC_EXT0;
		for (int s = NUM_SRC - 1; s >= 0; s--) begin
			lv = {prio_high_bit[s], prio_low_bit[s]};
			if (pend[s] && (!best_found || lv >= best_lvl)) begin
				best_found = 1'b1;
				best_lvl   = lv;
				best_src   = SRC_W'(s);
			end
		end
	end

	// Highest level now in service; only meaningful when some bit is set
	always_comb begin
		cur_lvl = LVL_LOWEST;
		for (int l = 0; l <= int'(LVL_HIGHEST); l++) begin
			if (in_service_r[l])
				cur_lvl = LVL_W'(l);
		end
	end

	// Strictly greater: equal level never preempts, level 0 never does.
	// With nothing in service any pending level may be requested.
	assign take = best_found && (in_service_r == INSVC_RST || best_lvl > cur_lvl);

	// Request is dropped in the acknowledge cycle so the old in-service
	// state cannot produce a stale second request
	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq_req_r    <= 1'b0;
			irq_vector_r <= VEC_EXT0;
			irq_level_r  <= LVL_LOWEST;
			req_src_r    <= SRC_EXT0;
		end else if (ack_ok) begin
			irq_req_r <= 1'b0;
		end else begin
			irq_req_r    <= take;
			irq_vector_r <= vec_of(best_src);
			irq_level_r  <= best_lvl;
			req_src_r    <= best_src;
		end
	end

	// One bit per level; return retires the highest active one.
	// Nesting depth is bounded by the four levels, since a level can only
	// be entered from below. An acknowledge in the same cycle as a return
	// wins; the core must not overlap them.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			in_service_r <= INSVC_RST;
		end else if (ack_ok) begin
			in_service_r[irq_level_r] <= 1'b1;
		end else if (irq_return && in_service_r != INSVC_RST) begin
			in_service_r[cur_lvl] <= 1'b0;
		end
	end

	// One-cycle strobes telling the timers to drop their overflow flags,
	// since the timer flags are owned by the timer blocks themselves.
	// The serial and card flags are not cleared here: software owns them.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			timer0_flag_clr_r <= 1'b0;
			timer1_flag_clr_r <= 1'b0;
		end else begin
			timer0_flag_clr_r <= ack_ok && req_src_r == SRC_TMR0;
			timer1_flag_clr_r <= ack_ok && req_src_r == SRC_TMR1;
		end
	end

endmodule

// >>> verilog/mpi_pkg.sv
package mpi_pkg;

	localparam int unsigned NUM_SRC = 6;
	localparam int unsigned LVL_W   = 2;
	localparam int unsigned VEC_W   = 16;
	localparam int unsigned SRC_W   = 3;
	localparam int unsigned NUM_PIN = 4;

	// Source index, also the polling order inside a level (lowest index wins)
	localparam logic [SRC_W-1:0] SRC_EXT0   = 3'h0;
	localparam logic [SRC_W-1:0] SRC_TMR0   = 3'h1;
	localparam logic [SRC_W-1:0] SRC_EXT1   = 3'h2;
	localparam logic [SRC_W-1:0] SRC_TMR1   = 3'h3;
	localparam logic [SRC_W-1:0] SRC_SERIAL = 3'h4;
	localparam logic [SRC_W-1:0] SRC_CARD   = 3'h5;

	// Vector addresses
	localparam logic [VEC_W-1:0] VEC_EXT0   = 16'h0003;
	localparam logic [VEC_W-1:0] VEC_TMR0   = 16'h000b;
	localparam logic [VEC_W-1:0] VEC_EXT1   = 16'h0013;
	localparam logic [VEC_W-1:0] VEC_TMR1   = 16'h001b;
	localparam logic [VEC_W-1:0] VEC_SERIAL = 16'h0023;
	localparam logic [VEC_W-1:0] VEC_CARD   = 16'h0053;

	// Priority levels
	localparam logic [LVL_W-1:0] LVL_LOWEST  = 2'h0;
	localparam logic [LVL_W-1:0] LVL_HIGHEST = 2'h3;

	// Bit positions of the synchronised pin vector
	localparam int unsigned PIN_EXT0 = 0;
	localparam int unsigned PIN_EXT1 = 1;
	localparam int unsigned PIN_RX   = 2;
	localparam int unsigned PIN_CARD = 3;

	// Reset values; pins idle high
	localparam logic [NUM_PIN-1:0] PIN_RST = 4'hf;
	localparam logic [NUM_SRC-1:0] SRC_RST = 6'h00;
	localparam logic [LVL_W+1:0]   INSVC_RST = 4'h0;

endpackage

// >>> sim/mpi_ctrl_assertions.sv
`timescale 1ns/100ps
module mpi_ctrl_chk
	import mpi_pkg::*;
(
	input wire logic               core_clk,
	input wire logic               srst,
	input wire logic               global_irq_enable,
	input wire logic               irq_ack,
	input wire logic               irq_req_r,
	input wire logic [VEC_W-1:0]   irq_vector_r,
	input wire logic [LVL_W-1:0]   irq_level_r,
	input wire logic [LVL_W+1:0]   in_service_r,
	input wire logic [NUM_SRC-1:0] prio_high_bit,
	input wire logic [NUM_SRC-1:0] prio_low_bit,
	input wire logic               out_en_irq_en,
	input wire logic               ext1_edge_select,
	input wire logic               ext1_flag_r,
	input wire logic               card_detect_flag_r,
	input wire logic               card_detect_flag_clr,
	input wire logic               timer0_flag_clr_r
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence s_taken;
		irq_req_r && irq_ack;
	endsequence
	sequence s_t0_taken;
		s_taken ##0 irq_vector_r == VEC_TMR0;
	endsequence
	property p_glob;
		!global_irq_enable [*2] |-> !irq_req_r;
	endproperty
	property p_ack;
		s_taken |=> !irq_req_r && in_service_r[$past(irq_level_r)];
	endproperty
	property p_pre;
		irq_req_r |-> (in_service_r >> irq_level_r) == 4'h0;
	endproperty
	property p_top;
		in_service_r[3] |-> !irq_req_r;
	endproperty
	property p_lvl;
		irq_req_r && irq_vector_r == VEC_TMR0 |->
			irq_level_r == $past({prio_high_bit[SRC_TMR0], prio_low_bit[SRC_TMR0]});
	endproperty
	property p_gate;
		!out_en_irq_en [*2] |-> !ext1_flag_r;
	endproperty
	property p_e1clr;
		s_taken ##0 (irq_vector_r == VEC_EXT1 && ext1_edge_select) |=> !ext1_flag_r;
	endproperty
	property p_card;
		card_detect_flag_r && !card_detect_flag_clr |=> card_detect_flag_r;
	endproperty
	property p_tclr;
		s_t0_taken |=> timer0_flag_clr_r ##1 !timer0_flag_clr_r;
	endproperty
	a_glob: assert property (p_glob) else $error("request while globally disabled");
	a_ack: assert property (p_ack) else $error("ack did not start service");
	a_pre: assert property (p_pre) else $error("request not above service level");
	a_top: assert property (p_top) else $error("top level preempted");
	a_lvl: assert property (p_lvl) else $error("level does not match prio bits");
	a_gate: assert property (p_gate) else $error("ext1 flag while pin disabled");
	a_e1clr: assert property (p_e1clr) else $error("ext1 flag kept after vector");
	a_card: assert property (p_card) else $error("card flag lost without clear");
	a_tclr: assert property (p_tclr) else $error("timer clear pulse wrong");
endmodule
bind mpi_ctrl mpi_ctrl_chk u_mpi_ctrl_chk (.core_clk, .srst, .global_irq_enable, .irq_ack,
	.irq_req_r, .irq_vector_r, .irq_level_r, .in_service_r, .prio_high_bit, .prio_low_bit,
	.out_en_irq_en, .ext1_edge_select, .ext1_flag_r, .card_detect_flag_r,
	.card_detect_flag_clr, .timer0_flag_clr_r);

// >>> sim/mpi_cpu_model.sv
`timescale 1ns/100ps
// Core side: takes a vector only when told, so the bench can inspect it first
module mpi_cpu_model (
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic irq_req_r,
	input  wire logic take,
	input  wire logic give_back,
	output logic      irq_ack,
	output logic      irq_return
);
	always_ff @(posedge core_clk) begin
		irq_ack <= !srst && irq_req_r && take && !irq_ack;
	end
	always_ff @(posedge core_clk) begin
		irq_return <= !srst && give_back && !irq_return;
	end
endmodule

// >>> sim/tb_mpi_ctrl.sv
`timescale 1ns/100ps
module tb_mpi_ctrl;
	import mpi_pkg::*;
	logic core_clk, srst, ext0_in, ext1_out_en_in, rx_pin_in, card_detect_in, irq_ack;
	logic timer0_overflow_flag, timer1_overflow_flag, rx_done_flag, tx_done_flag, card_if_irq;
	logic global_irq_enable, ext0_enable, timer0_irq_en, ext1_enable, timer1_irq_en;
	logic serial_irq_en, card_if_irq_en, ext0_edge_select, ext1_edge_select, out_en_irq_en;
	logic out_en_level_sel, rx_pin_irq_en, card_detect_irq_en, card_detect_level_sel;
	logic rx_pin_flag_clr, card_detect_flag_clr, irq_return, irq_req_r, take, give_back;
	logic ext0_flag_r, ext1_flag_r, rx_pin_flag_r, card_detect_flag_r;
	logic timer0_flag_clr_r, timer1_flag_clr_r;
	logic [NUM_SRC-1:0] prio_high_bit, prio_low_bit;
	logic [VEC_W-1:0]   irq_vector_r;
	logic [LVL_W-1:0]   irq_level_r;
	logic [LVL_W+1:0]   in_service_r;
	int                 errors, samples_checked;
	mpi_ctrl u_mpi_ctrl (.*);
	mpi_cpu_model u_mpi_cpu_model (.core_clk, .srst, .irq_req_r, .take, .give_back, .irq_ack,
		.irq_return);
	initial begin
		core_clk = 0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Timers drop their flags when told, as the real timers would
	always @(posedge core_clk) begin
		if (timer0_flag_clr_r) timer0_overflow_flag <= 1'b0;
		if (timer1_flag_clr_r) timer1_overflow_flag <= 1'b0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	task automatic test_done;
		if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wreq(input logic [15:0] v);
		int i;
		for (i = 0; i < 20 && irq_req_r !== 1'b1; i++) step(1);
		if (i == 20) begin
			errors++;
			test_done();
		end
		chk("vector", irq_vector_r, v);
	endtask
	task automatic ack;
		take = 1;
		step(2);
		take = 0;
		step(1);
	endtask
	task automatic ret;
		give_back = 1;
		step(1);
		give_back = 0;
		step(2);
	endtask
	task automatic setp(input int s, input logic [1:0] l);
		{prio_high_bit[s], prio_low_bit[s]} = l;
	endtask
	initial begin
		{srst, ext0_in, ext1_out_en_in, rx_pin_in, card_detect_in} = 5'h1f;
		{timer0_overflow_flag, timer1_overflow_flag, rx_done_flag, tx_done_flag} = 4'h0;
		{card_if_irq, ext0_edge_select, ext1_edge_select, out_en_irq_en, take} = 5'h00;
		{out_en_level_sel, rx_pin_irq_en, card_detect_irq_en, card_detect_level_sel} = 4'h0;
		{rx_pin_flag_clr, card_detect_flag_clr, give_back, prio_high_bit} = 9'h000;
		{global_irq_enable, ext0_enable, timer0_irq_en, ext1_enable} = 4'hf;
		{timer1_irq_en, serial_irq_en, card_if_irq_en, prio_low_bit} = 9'h1c0;
		step(2);
		srst = 0;
		step(3);
		chk("rst_vec", irq_vector_r, VEC_EXT0);
		chk("rst_svc", in_service_r, 0);
		setp(1, 1);
		setp(3, 2);
		{timer0_overflow_flag, timer1_overflow_flag} = 2'h3;
		wreq(VEC_TMR1);
		chk("lvl", irq_level_r, 2);
		ack();
		chk("svc", in_service_r, 4'h4);
		chk("t1_clr", timer1_overflow_flag, 0);
		step(6);
		chk("no_pre", irq_req_r, 0);
		setp(1, 3);
		wreq(VEC_TMR0);
		ack();
		rx_done_flag = 1;
		setp(4, 3);
		step(6);
		chk("top", irq_req_r, 0);
		ret();
		wreq(VEC_SERIAL);
		ack();
		rx_done_flag = 0;
		ret();
		ret();
		chk("svc0", in_service_r, 0);
		{prio_high_bit, prio_low_bit} = 12'h000;
		{timer1_overflow_flag, rx_done_flag, card_if_irq} = 3'h7;
		wreq(VEC_TMR1);
		ack();
		ret();
		wreq(VEC_SERIAL);
		ack();
		rx_done_flag = 0;
		ret();
		wreq(VEC_CARD);
		ack();
		card_if_irq = 0;
		ret();
		global_irq_enable = 0;
		timer0_overflow_flag = 1;
		step(6);
		chk("global", irq_req_r, 0);
		{global_irq_enable, timer0_irq_en} = 2'h2;
		step(6);
		chk("own_en", irq_req_r, 0);
		timer0_irq_en = 1;
		wreq(VEC_TMR0);
		ack();
		chk("t0_clr", timer0_overflow_flag, 0);
		ret();
		{ext1_edge_select, ext1_out_en_in} = 2'h2;
		step(6);
		chk("oe_off", ext1_flag_r, 0);
		ext1_out_en_in = 1;
		step(4);
		out_en_irq_en = 1;
		ext1_out_en_in = 0;
		wreq(VEC_EXT1);
		chk("e1_set", ext1_flag_r, 1);
		ack();
		chk("e1_clr", ext1_flag_r, 0);
		ret();
		{ext1_out_en_in, ext1_edge_select, out_en_level_sel} = 3'h5;
		step(5);
		chk("lvl1", ext1_flag_r, 1);
		out_en_level_sel = 0;
		step(5);
		chk("lvl0", ext1_flag_r, 0);
		chk("e1_drop", irq_req_r, 0);
		{out_en_irq_en, rx_pin_in} = 2'h0;
		step(5);
		chk("rx_flag", rx_pin_flag_r, 1);
		chk("rx_off", irq_req_r, 0);
		rx_pin_irq_en = 1;
		wreq(VEC_EXT1);
		{rx_pin_in, rx_pin_flag_clr} = 2'h3;
		step(4);
		rx_pin_flag_clr = 0;
		step(4);
		chk("rx_clr", rx_pin_flag_r, 0);
		{card_detect_irq_en, card_detect_in} = 2'h2;
		wreq(VEC_EXT1);
		chk("cd_set", card_detect_flag_r, 1);
		card_detect_in = 1;
		step(5);
		chk("cd_hold", card_detect_flag_r, 1);
		card_detect_flag_clr = 1;
		step(1);
		card_detect_flag_clr = 0;
		step(2);
		chk("cd_clr", card_detect_flag_r, 0);
		chk("cd_idle", irq_req_r, 0);
		ext0_edge_select = 1;
		ext0_in = 0;
		wreq(VEC_EXT0);
		chk("e0_set", ext0_flag_r, 1);
		ack();
		chk("e0_clr", ext0_flag_r, 0);
		ret();
		chk("svc_end", in_service_r, 0);
		test_done();
	end
endmodule
